// >>> ext_pin_irq_defs.svh
`ifndef EXT_PIN_IRQ_DEFS_SVH
`define EXT_PIN_IRQ_DEFS_SVH

// Pin counts and register widths.
`define EPI_PORT_PINS 16
`define EPI_REQ_PINS 6
`define EPI_GROUP_PINS 8
`define EPI_FLAGS_W 8
`define EPI_REQ_SENSE_W 12
`define EPI_ADDR_W 12

// Register byte offsets on the APB.
`define EPI_OFS_SENSE 12'h000
`define EPI_OFS_ENABLE 12'h004
`define EPI_OFS_FLAGS 12'h008
`define EPI_OFS_REQ_SENSE 12'h00c
`define EPI_OFS_IRQ_STATUS 12'h010
`define EPI_OFS_IRQ_MASK 12'h014
`define EPI_OFS_PIN_LEVEL 12'h018

// Reset values.
`define EPI_SENSE_RST 16'h0000
`define EPI_ENABLE_RST 16'h0000
`define EPI_FLAGS_RST 8'h00
`define EPI_REQ_SENSE_RST 12'h000
`define EPI_IRQ_RST 8'h00

// Field positions inside the request flag register and the level register.
`define EPI_LOW_GROUP_BIT 7
`define EPI_HIGH_GROUP_BIT 6
`define EPI_LEVEL_REQ_LSB 16

// Cycles after reset release before edge detection trusts the pin history.
`define EPI_WARM_CYCLES 2'h3

`endif

// >>> ext_pin_irq_pkg.sv
package ext_pin_irq_pkg;

	typedef enum logic [1:0] {
		sense_fall = 2'b00,
		sense_rise = 2'b01,
		sense_low = 2'b10,
		sense_reserved = 2'b11
	} req_sense_t;

	typedef logic [31:0] apb_word_t;

endpackage

// >>> ext_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module ext_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second one.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

`default_nettype wire

// >>> ext_pin_irq_detect_flags.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ext_pin_irq_defs.svh"

module ext_pin_irq_detect_flags
	import ext_pin_irq_pkg::*;
#(
	parameter int ADDR_W = `EPI_ADDR_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`EPI_PORT_PINS-1:0] port_irq_pin,
	input wire logic [`EPI_REQ_PINS-1:0] ext_request_pin,
	output logic low_port_group_flag,
	output logic high_port_group_flag,
	output logic [`EPI_REQ_PINS-1:0] request_pin_irq,
	output logic irq
);

	// Reset release is synchronised; assertion stays asynchronous.
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Pin inputs come from outside the clock domain.
	logic [`EPI_PORT_PINS-1:0] port_level;
	logic [`EPI_REQ_PINS-1:0] req_level;

	ext_pin_sync #(
		.WIDTH(`EPI_PORT_PINS)
	) port_sync (
		.clk(clk),
		.rst_n(rst_sync_n),
		.async_in(port_irq_pin),
		.sync_out(port_level)
	);

	ext_pin_sync #(
		.WIDTH(`EPI_REQ_PINS)
	) req_sync (
		.clk(clk),
		.rst_n(rst_sync_n),
		.async_in(ext_request_pin),
		.sync_out(req_level)
	);

	// The synchroniser holds reset values for two cycles after release, so
	// edges seen before the pipeline has filled would be false ones.
	logic [1:0] warm_count;
	logic primed;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			warm_count <= 2'h0;
		end else if (warm_count != `EPI_WARM_CYCLES) begin
			warm_count <= warm_count + 2'h1;
		end
	end

	assign primed = (warm_count == `EPI_WARM_CYCLES);

	// APB decode.
	logic setup_phase;
	logic access_phase;
	logic addr_hit;
	logic wr_access;
	logic rd_access;
	logic wr_sense;
	logic wr_enable;
	logic wr_flags;
	logic wr_req_sense;
	logic wr_status;
	logic wr_mask;
	logic rd_flags;

	always_comb begin
		case (paddr)
			`EPI_OFS_SENSE,
			`EPI_OFS_ENABLE,
			`EPI_OFS_FLAGS,
			`EPI_OFS_REQ_SENSE,
			`EPI_OFS_IRQ_STATUS,
			`EPI_OFS_IRQ_MASK,
			`EPI_OFS_PIN_LEVEL: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access = access_phase & pwrite & addr_hit;
	assign rd_access = access_phase & ~pwrite & addr_hit;
	assign wr_sense = wr_access & (paddr == `EPI_OFS_SENSE);
	assign wr_enable = wr_access & (paddr == `EPI_OFS_ENABLE);
	assign wr_flags = wr_access & (paddr == `EPI_OFS_FLAGS) & pstrb[0];
	assign wr_req_sense = wr_access & (paddr == `EPI_OFS_REQ_SENSE);
	assign wr_status = wr_access & (paddr == `EPI_OFS_IRQ_STATUS) & pstrb[0];
	assign wr_mask = wr_access & (paddr == `EPI_OFS_IRQ_MASK) & pstrb[0];
	assign rd_flags = rd_access & (paddr == `EPI_OFS_FLAGS);

	// Every access completes in its first access cycle.
	assign pready = 1'b1;
	assign pslverr = access_phase & ~addr_hit;

	// Port pin sense and enable registers, written per byte lane.
	logic [`EPI_PORT_PINS-1:0] port_pin_sense_select;
	logic [`EPI_PORT_PINS-1:0] port_pin_request_enable;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			port_pin_sense_select <= `EPI_SENSE_RST;
		end else if (wr_sense) begin
			if (pstrb[0]) begin
				port_pin_sense_select[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				port_pin_sense_select[15:8] <= pwdata[15:8];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			port_pin_request_enable <= `EPI_ENABLE_RST;
		end else if (wr_enable) begin
			if (pstrb[0]) begin
				port_pin_request_enable[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				port_pin_request_enable[15:8] <= pwdata[15:8];
			end
		end
	end

	// Request pin sense fields, two bits per pin.
	logic [`EPI_REQ_SENSE_W-1:0] request_pin_sense_control;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			request_pin_sense_control <= `EPI_REQ_SENSE_RST;
		end else if (wr_req_sense) begin
			if (pstrb[0]) begin
				request_pin_sense_control[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				request_pin_sense_control[11:8] <= pwdata[11:8];
			end
		end
	end

	// Port pin requests and their two group flags.
	logic [`EPI_PORT_PINS-1:0] port_request;

	genvar gp;
	generate
		for (gp = 0; gp < `EPI_PORT_PINS; gp = gp + 1) begin : g_port
			assign port_request[gp] = port_pin_request_enable[gp]
				& (port_level[gp] == port_pin_sense_select[gp]);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			low_port_group_flag <= 1'b0;
			high_port_group_flag <= 1'b0;
		end else begin
			low_port_group_flag <= |port_request[7:0];
			high_port_group_flag <= |port_request[15:8];
		end
	end

	// External request pin detection, one flag per pin.
	logic [`EPI_REQ_PINS-1:0] request_pin_flag;
	logic [`EPI_REQ_PINS-1:0] read_armed;
	logic [`EPI_REQ_PINS-1:0] level_prev;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			level_prev <= '0;
		end else begin
			level_prev <= req_level;
		end
	end

	genvar gr;
	generate
		for (gr = 0; gr < `EPI_REQ_PINS; gr = gr + 1) begin : g_req
			req_sense_t mode;
			logic edge_seen;
			logic clear_req;

			assign mode = req_sense_t'(request_pin_sense_control[2*gr +: 2]);

			always_comb begin
				case (mode)
					sense_fall: edge_seen = level_prev[gr] & ~req_level[gr];
					sense_rise: edge_seen = ~level_prev[gr] & req_level[gr];
					default: edge_seen = 1'b0;
				endcase
			end

			// A written 1 leaves the flag alone; a 0 clears it only after
			// software has seen it set, so a blind write cannot lose a request.
			assign clear_req = wr_flags & ~pwdata[gr] & read_armed[gr];

			// A new edge in the same cycle as a clear keeps the flag set.
			always_ff @(posedge clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					request_pin_flag[gr] <= 1'b0;
				end else if (mode == sense_low) begin
					request_pin_flag[gr] <= ~req_level[gr];
				end else if (primed && edge_seen) begin
					request_pin_flag[gr] <= 1'b1;
				end else if (clear_req) begin
					request_pin_flag[gr] <= 1'b0;
				end
			end

			always_ff @(posedge clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					read_armed[gr] <= 1'b0;
				end else if (rd_flags) begin
					read_armed[gr] <= prdata[gr];
				end else if (clear_req || !request_pin_flag[gr]) begin
					read_armed[gr] <= 1'b0;
				end
			end
		end
	endgenerate

	// The latched flag is the request handed on to the priority logic.
	assign request_pin_irq = request_pin_flag;

	logic [`EPI_FLAGS_W-1:0] external_request_flags;

	always_comb begin
		external_request_flags = `EPI_FLAGS_RST;
		external_request_flags[`EPI_REQ_PINS-1:0] = request_pin_flag;
		external_request_flags[`EPI_LOW_GROUP_BIT] = low_port_group_flag;
		external_request_flags[`EPI_HIGH_GROUP_BIT] = high_port_group_flag;
	end

	// Interrupt status: each flag rising sets a sticky bit, write 1 clears.
	logic [`EPI_FLAGS_W-1:0] flags_prev;
	logic [`EPI_FLAGS_W-1:0] flag_event;
	logic [`EPI_FLAGS_W-1:0] irq_status;
	logic [`EPI_FLAGS_W-1:0] irq_mask;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flags_prev <= `EPI_FLAGS_RST;
		end else begin
			flags_prev <= external_request_flags;
		end
	end

	assign flag_event = external_request_flags & ~flags_prev;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_status <= `EPI_IRQ_RST;
		end else if (wr_status) begin
			irq_status <= (irq_status & ~pwdata[7:0]) | flag_event;
		end else begin
			irq_status <= irq_status | flag_event;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_mask <= `EPI_IRQ_RST;
		end else if (wr_mask) begin
			irq_mask <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// Read data is captured in the setup cycle so it is stable during the
	// access cycle; a flag read arms the clear with exactly what was returned.
	apb_word_t rd_word;

	always_comb begin
		rd_word = '0;
		case (paddr)
			`EPI_OFS_SENSE: rd_word[15:0] = port_pin_sense_select;
			`EPI_OFS_ENABLE: rd_word[15:0] = port_pin_request_enable;
			`EPI_OFS_FLAGS: rd_word[7:0] = external_request_flags;
			`EPI_OFS_REQ_SENSE: rd_word[11:0] = request_pin_sense_control;
			`EPI_OFS_IRQ_STATUS: rd_word[7:0] = irq_status;
			`EPI_OFS_IRQ_MASK: rd_word[7:0] = irq_mask;
			`EPI_OFS_PIN_LEVEL: begin
				rd_word[15:0] = port_level;
				rd_word[`EPI_LEVEL_REQ_LSB +: `EPI_REQ_PINS] = req_level;
			end
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata <= '0;
		end else if (setup_phase && !pwrite) begin
			prdata <= rd_word;
		end
	end

endmodule

`default_nettype wire

// >>> ext_pin_irq_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_pin_irq_defs.svh"
module ext_pin_irq_chk #(
	parameter int ADDR_W = `EPI_ADDR_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic [`EPI_PORT_PINS-1:0] port_irq_pin,
	input wire logic [`EPI_REQ_PINS-1:0] ext_request_pin,
	input wire logic low_port_group_flag,
	input wire logic high_port_group_flag,
	input wire logic [`EPI_REQ_PINS-1:0] request_pin_irq,
	input wire logic irq
);
	logic [21:0] prev_pins;
	logic [2:0] pin_quiet;
	logic [2:0] bus_quiet;
	wire logic [7:0] flag_vec;
	assign flag_vec = {low_port_group_flag, high_port_group_flag,
		request_pin_irq};
	// Pins pass a synchroniser and a flag register, the interrupt two more
	// flops, so seven quiet cycles leave every output settled.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_pins <= '0;
			pin_quiet <= '0;
			bus_quiet <= '0;
		end else begin
			prev_pins <= {port_irq_pin, ext_request_pin};
			if (prev_pins != {port_irq_pin, ext_request_pin})
				pin_quiet <= '0;
			else if (pin_quiet != 3'h7)
				pin_quiet <= pin_quiet + 3'h1;
			if (psel)
				bus_quiet <= '0;
			else if (bus_quiet != 3'h7)
				bus_quiet <= bus_quiet + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_read_flags;
		psel && penable && !pwrite && paddr == `EPI_OFS_FLAGS;
	endsequence
	sequence s_write_flags;
		psel && penable && pwrite && paddr == `EPI_OFS_FLAGS;
	endsequence
	AST_RESET_FLAGS: assert property (
		$rose(rst_n) |-> (flag_vec == 8'h00 && !irq) [*2])
		else $error("flags not clear after reset");
	AST_READ_GROUP: assert property (
		s_read_flags |-> prdata[7:6] ==
		$past({low_port_group_flag, high_port_group_flag}))
		else $error("group flag readback differs");
	AST_READ_PINS: assert property (
		s_read_flags |-> prdata[5:0] == $past(request_pin_irq))
		else $error("request flag readback differs");
	AST_READ_UPPER: assert property (
		s_read_flags |-> prdata[31:8] == 24'h0)
		else $error("flag register upper bits set");
	AST_REG_WIDTH: assert property (
		psel && penable && !pwrite && paddr < 12'h008 |-> prdata[31:16] == 0)
		else $error("sense or enable upper bits set");
	AST_NO_SET_BY_WRITE: assert property (
		s_write_flags and pin_quiet >= 3'h5 |=>
		(request_pin_irq & ~$past(request_pin_irq)) == '0)
		else $error("write set a request flag");
	AST_QUIET_STABLE: assert property (
		pin_quiet == 3'h7 && bus_quiet == 3'h7 |-> $stable({flag_vec, irq}))
		else $error("flags moved with quiet pins and bus");
	AST_CLEAR_CAUSE: assert property (
		|($past(request_pin_irq) & ~request_pin_irq) |->
		$past(psel && penable && pwrite) || pin_quiet < 3'h5)
		else $error("request flag fell without cause");
endmodule
bind ext_pin_irq_detect_flags ext_pin_irq_chk #(.ADDR_W(ADDR_W)) i_chk (
	.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .port_irq_pin,
	.ext_request_pin, .low_port_group_flag, .high_port_group_flag,
	.request_pin_irq, .irq);
`default_nettype wire

// >>> ext_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pin_source (
	input wire logic clk,
	input wire logic [15:0] port_level,
	input wire logic [5:0] req_level,
	output var logic [15:0] port_irq_pin = 16'hffff,
	output var logic [5:0] ext_request_pin = 6'h3f
);
	// Devices change their pins just after an edge, never at the sample.
	always @(posedge clk) begin
		port_irq_pin <= port_level;
		ext_request_pin <= req_level;
	end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_pin_irq_defs.svh"
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, last_err, irq;
	logic low_port_group_flag, high_port_group_flag;
	logic [15:0] port_level = 16'hffff;
	logic [5:0] req_level = 6'h3f;
	logic [15:0] port_irq_pin;
	logic [5:0] ext_request_pin, request_pin_irq;
	int num_errors = 0;
	int total_checks = 0;
	always #20 clk = ~clk;
	ext_pin_source i_src (.clk, .port_level, .req_level, .port_irq_pin,
		.ext_request_pin);
	ext_pin_irq_detect_flags #(.ADDR_W(12)) i_dut (.clk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .port_irq_pin, .ext_request_pin, .low_port_group_flag,
		.high_port_group_flag, .request_pin_irq, .irq);
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [8:0] exp);
		chk32({23'h0, irq, low_port_group_flag, high_port_group_flag,
			request_pin_irq}, {23'h0, exp});
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n == 16) begin
			num_errors++;
			tally_and_finish();
		end
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk32(r, exp);
	endtask
	// Pin to irq takes five cycles, six from the level set here; eight leaves margin.
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask
	initial begin
		logic [3:0] lo_exp, hi_exp;
		lo_exp = 4'b0101;
		hi_exp = 4'b0011;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`EPI_OFS_SENSE, 32'h0);
		rd(`EPI_OFS_ENABLE, 32'h0);
		rd(`EPI_OFS_FLAGS, 32'h0);
		wr(`EPI_OFS_SENSE, 32'hffffa5c3);
		rd(`EPI_OFS_SENSE, 32'h0000a5c3);
		wr(`EPI_OFS_ENABLE, 32'h12345a81);
		rd(`EPI_OFS_ENABLE, 32'h00005a81);
		settle();
		chk_out(9'h080);
		port_level <= 16'hff7e;
		settle();
		chk_out(9'h000);
		wr(`EPI_OFS_ENABLE, 32'h8000);
		settle();
		chk_out(9'h040);
		wr(`EPI_OFS_ENABLE, 32'h0);
		settle();
		chk_out(9'h000);
		wr(`EPI_OFS_IRQ_MASK, 32'h3f);
		for (int m = 0; m < 4; m++) begin
			wr(`EPI_OFS_REQ_SENSE, m);
			req_level[0] <= 1'b0;
			settle();
			chk_out({lo_exp[m], 7'h0, lo_exp[m]});
			req_level[0] <= 1'b1;
			settle();
			chk_out({lo_exp[m] | hi_exp[m], 7'h0, hi_exp[m]});
			rd(`EPI_OFS_FLAGS, {31'h0, hi_exp[m]});
			wr(`EPI_OFS_FLAGS, 32'h0);
			wr(`EPI_OFS_IRQ_STATUS, 32'hff);
			settle();
			chk_out(9'h000);
		end
		wr(`EPI_OFS_REQ_SENSE, 32'h0);
		req_level[2] <= 1'b0;
		settle();
		wr(`EPI_OFS_FLAGS, 32'hff);
		settle();
		chk_out(9'h104);
		wr(`EPI_OFS_FLAGS, 32'h0);
		settle();
		chk_out(9'h104);
		rd(`EPI_OFS_FLAGS, 32'h04);
		wr(`EPI_OFS_FLAGS, 32'h0);
		settle();
		chk_out(9'h100);
		wr(`EPI_OFS_IRQ_MASK, 32'h0);
		settle();
		chk_out(9'h000);
		wr(`EPI_OFS_IRQ_MASK, 32'h3f);
		settle();
		chk_out(9'h100);
		rd(`EPI_OFS_IRQ_STATUS, 32'h04);
		wr(`EPI_OFS_IRQ_STATUS, 32'h04);
		settle();
		chk_out(9'h000);
		wr(`EPI_OFS_REQ_SENSE, 32'hfffffe4b);
		rd(`EPI_OFS_REQ_SENSE, 32'h00000e4b);
		// A second reset in mid-run must clear what software set.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk_out(9'h000);
		rd(`EPI_OFS_SENSE, 32'h0);
		rd(`EPI_OFS_REQ_SENSE, 32'h0);
		rd(`EPI_OFS_PIN_LEVEL, 32'h003bff7e);
		rd(12'h01c, 32'h0);
		chk32({31'h0, last_err}, 32'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
